// file: include/tspf_pkg.sv
// Package holding the constants, types and register map of the trace sync packet framer.
package tspf_pkg;

    // ------------------------------------------------------------------
    // Packet header codes
    // ------------------------------------------------------------------
    localparam logic [7:0] HDR_ASYNC     = 8'h00;
    localparam logic [7:0] ASYNC_END     = 8'h80;
    localparam logic [7:0] HDR_ISYNC     = 8'h08;
    localparam logic [7:0] HDR_TRIGGER   = 8'h0C;
    localparam logic [7:0] HDR_EXC_RET   = 8'h76;
    localparam logic [7:0] HDR_IGNORE    = 8'h66;
    localparam logic [7:0] HDR_WP_UPDATE = 8'h72;
    localparam logic [7:0] HDR_CTXID     = 8'h6E;
    localparam logic [7:0] HDR_VIRTUAL_MACHINE_ID      = 8'h3C;

    // ------------------------------------------------------------------
    // Counts and reason codes
    // ------------------------------------------------------------------
    localparam logic [2:0] ASYNC_ZERO_COUNT = 3'h5;
    localparam logic [3:0] ISYNC_FIXED_LEN  = 4'h6;
    localparam logic [1:0] REASON_PERIODIC  = 2'h0;
    localparam logic [1:0] REASON_TRACE_ON  = 2'h1;
    localparam logic [1:0] REASON_OVERFLOW  = 2'h2;
    localparam logic [1:0] REASON_DEBUG     = 2'h3;

    // ------------------------------------------------------------------
    // Register map and control fields
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] VIRTUAL_MACHINE_ID_OFFSET   = 12'h008;
    localparam int          CTRL_TRACE_EN = 0;
    localparam int          CTRL_HOLD     = 1;
    localparam int          CTRL_CYC_EXACT = 12;
    localparam int          CTRL_CTXID_EN = 13;
    localparam int          CTRL_CTXW_LSB = 14;
    localparam int          CTRL_HALT_DBG = 16;
    localparam int          CTRL_VIRT     = 17;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0002;
    localparam logic [7:0]  VIRTUAL_MACHINE_ID_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic        compact_isa;
        logic        alternate_isa_bit;
        logic        nonsecure_bit;
        logic        hyp;
        logic        dbg_exit;
        logic [31:0] ctxid;
    } tspf_wp_t;

    typedef enum logic [2:0] {
        MISC_TRIGGER = 3'h0,
        MISC_EXC_RET = 3'h1,
        MISC_IGNORE  = 3'h2,
        MISC_VIRTUAL_MACHINE_ID    = 3'h3,
        MISC_CTXID   = 3'h4
    } tspf_misc_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ASYNC = 3'b010,
        ST_SEND  = 3'b100
    } tspf_state_t;

endpackage : tspf_pkg

// file: hw/tspf_framer.sv
// Trace sync packet framer: alignment and instruction sync packets onto a byte stream.
// Functional notes
// - Alignment packet is five zero bytes then one byte 0x80.
// - First packet after tracing turns on is an alignment packet; a misc request held in the turn-on cycle goes out first.
// - Clearing the hold bit emits an alignment packet before other output; a misc request held in that cycle goes out first.
// - A periodic sync request also inserts an alignment packet.
// - Instruction sync starts with header 0x08, payload five to fourteen bytes.
// - Header, four address bytes, information byte always come first, in order.
// - Up to five count bytes in cycle-exact nonperiodic packets; continuation bits chain.
// - Context id bytes 0, 1, 2 or 4 by width field, when enabled.
// - State bit is 0 for primary set, 1 for compact sets.
// - Information bits 6:5 carry the reason code.
// - Information bit 3 flags non-secure state.
// - Information bit 2 selects extended compact set, zero in primary set.
// - Information bit 1 flags hypervisor mode only with virtualization enabled.
// - Address choice depends on reason: latest waypoint or last nonperiodic address.
// - Context id bytes belong to the instruction at the packet address.
// - First count after enabling measures cycles since hold bit cleared.
// - Later counts run from the previous count to the named waypoint.
// - Periodic packets carry no count; nonperiodic cycle-exact carry compressed count.
// - Reason priority: debug exit, then overflow recovery, then normal enable.
// - Trigger, exception return and ignore are single header bytes.
// - Context id and machine id packets use their header codes.
// - Cycle-exact tracing is on while control bit 12 is set.
//
// The address map and register access over APB were left to the implementer.
module tspf_framer (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RST,
    // APB register port
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // Processor waypoint and event inputs
    input  wire logic             WP_VALID,
    input  wire tspf_pkg::tspf_wp_t WP_INFO,
    input  wire logic             PERIODIC_REQ,
    input  wire logic             OVF_RECOVERED,
    // Single-header and short packet requests
    input  wire logic             MISC_REQ,
    input  wire tspf_pkg::tspf_misc_t MISC_KIND,
    output logic                  MISC_ACK,
    // Trace byte stream
    output logic      [7:0]       TRACE_DATA,
    output logic                  TRACE_VALID,
    input  wire logic             TRACE_READY
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0]           ctrl;
    logic [7:0]            virtual_machine_id;
    tspf_pkg::tspf_state_t state;
    logic [3:0]            idx;
    logic [3:0]            len;
    logic [7:0]            pkt      [0:14];
    logic [7:0]            next_pkt [0:14];
    logic [3:0]            next_len;
    logic                  trace_on, trace_on_d, hold_d;
    logic                  enable_rise, hold_fall;
    logic                  async_pend, isync_pend, per_pend, ovf_pend, dbg_pend, first_pend;
    logic                  advance, async_done, start_np, start_per, start_misc, pkt_done;
    logic [31:0]           now, base_time, wp_time, cyc_val;
    tspf_pkg::tspf_wp_t    last_wp, last_np, sel_info;
    logic                  wp_since_np;
    logic [1:0]            reason;
    logic                  cyc_exact, ctx_en;

    // Maps a byte address to a register slot; zero means unmapped.
    function automatic logic [1:0] reg_slot(input logic [11:0] a);
        if (a == tspf_pkg::CTRL_OFFSET) begin
            reg_slot = 2'h1;
        end else if (a == tspf_pkg::STATUS_OFFSET) begin
            reg_slot = 2'h2;
        end else if (a == tspf_pkg::VIRTUAL_MACHINE_ID_OFFSET) begin
            reg_slot = 2'h3;
        end else begin
            reg_slot = 2'h0;
        end
    endfunction : reg_slot

    // Number of context id bytes selected by the width field.
    function automatic logic [3:0] ctx_bytes(input logic [1:0] w);
        case (w)
            2'h0:    ctx_bytes = 4'h0;
            2'h1:    ctx_bytes = 4'h1;
            2'h2:    ctx_bytes = 4'h2;
            default: ctx_bytes = 4'h4;
        endcase
    endfunction : ctx_bytes

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error.
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & (reg_slot(PADDR) == 2'h0);

    // Control and machine id registers take writes in the access phase.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl <= tspf_pkg::CTRL_RESET;
            virtual_machine_id <= tspf_pkg::VIRTUAL_MACHINE_ID_RESET;
        end else if (PSEL & PENABLE & PWRITE) begin
            if (reg_slot(PADDR) == 2'h1) begin
                ctrl <= PWDATA;
            end else if (reg_slot(PADDR) == 2'h3) begin
                virtual_machine_id <= PWDATA[7:0];
            end
        end
    end

    // Read data is captured in the setup phase so it leaves a flip-flop.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            case (reg_slot(PADDR))
                2'h1:    PRDATA <= ctrl;
                2'h2:    PRDATA <= {26'h0000000, first_pend, per_pend, isync_pend,
                                    async_pend, (state != tspf_pkg::ST_IDLE), trace_on};
                2'h3:    PRDATA <= {24'h000000, virtual_machine_id};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Enable tracking and event detection
    // ------------------------------------------------------------------
    assign trace_on    = ctrl[tspf_pkg::CTRL_TRACE_EN] & ~ctrl[tspf_pkg::CTRL_HOLD];
    assign cyc_exact   = ctrl[tspf_pkg::CTRL_CYC_EXACT];
    assign ctx_en      = ctrl[tspf_pkg::CTRL_CTXID_EN];
    assign enable_rise = trace_on & ~trace_on_d;
    assign hold_fall   = hold_d & ~ctrl[tspf_pkg::CTRL_HOLD];

    // Delayed copies feed the edge detectors above.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trace_on_d <= 1'b0;
            hold_d     <= 1'b1;
        end else begin
            trace_on_d <= trace_on;
            hold_d     <= ctrl[tspf_pkg::CTRL_HOLD];
        end
    end

    // ------------------------------------------------------------------
    // Pending packet flags
    // ------------------------------------------------------------------
    // Each set term wins over a clear in the same cycle, so no request is lost.
    // Turning tracing off drops whatever is still waiting.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            async_pend <= 1'b0;
            isync_pend <= 1'b0;
            per_pend   <= 1'b0;
            ovf_pend   <= 1'b0;
            dbg_pend   <= 1'b0;
        end else begin
            async_pend <= enable_rise | hold_fall
                        | (PERIODIC_REQ & trace_on)
                        | (async_pend & ~async_done & trace_on);
            isync_pend <= enable_rise | (OVF_RECOVERED & trace_on)
                        | (WP_VALID & WP_INFO.dbg_exit & trace_on)
                        | (isync_pend & ~start_np & trace_on);
            per_pend   <= (PERIODIC_REQ & trace_on)
                        | (per_pend & ~start_np & ~start_per & trace_on);
            ovf_pend   <= (OVF_RECOVERED & trace_on) | (ovf_pend & ~start_np & trace_on);
            dbg_pend   <= (WP_VALID & WP_INFO.dbg_exit & trace_on)
                        | (dbg_pend & ~start_np & trace_on);
        end
    end

    // Nonperiodic reason by fixed priority.
    always_comb begin
        if (dbg_pend & ctrl[tspf_pkg::CTRL_HALT_DBG]) begin
            reason = tspf_pkg::REASON_DEBUG;
        end else if (ovf_pend) begin
            reason = tspf_pkg::REASON_OVERFLOW;
        end else if (isync_pend) begin
            reason = tspf_pkg::REASON_TRACE_ON;
        end else begin
            reason = tspf_pkg::REASON_PERIODIC;
        end
    end

    // ------------------------------------------------------------------
    // Waypoint tracking
    // ------------------------------------------------------------------
    // Waypoints are followed even while tracing is off, so that the first
    // packet after enabling names the most recent one.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            last_wp     <= '0;
            last_np     <= '0;
            wp_time     <= 32'h0000_0000;
            wp_since_np <= 1'b0;
        end else begin
            if (WP_VALID) begin
                last_wp <= WP_INFO;
                wp_time <= now;
            end
            if (start_np) begin
                last_np <= sel_info;
            end
            wp_since_np <= WP_VALID | (wp_since_np & ~start_np);
        end
    end

    // Periodic packets fall back to the last nonperiodic address when no waypoint has come since that packet.
    assign sel_info = (reason == tspf_pkg::REASON_PERIODIC && !wp_since_np)
                    ? last_np : last_wp;

    // ------------------------------------------------------------------
    // Cycle counting
    // ------------------------------------------------------------------
    // A free-running time base; counts are differences, so wrap is harmless.
    // The first count measures up to packet start, later ones up to the waypoint.
    assign cyc_val = first_pend ? (now - base_time)
                                : (wp_time - base_time);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            now        <= 32'h0000_0000;
            base_time  <= 32'h0000_0000;
            first_pend <= 1'b0;
        end else begin
            now <= now + 32'h0000_0001;
            if (hold_fall) begin
                base_time <= now;
            end else if (start_np & cyc_exact) begin
                base_time <= first_pend ? now : wp_time;
            end
            first_pend <= hold_fall | (first_pend & ~start_np);
        end
    end

    // ------------------------------------------------------------------
    // Packet composition
    // ------------------------------------------------------------------
    assign start_np   = (state == tspf_pkg::ST_IDLE) & trace_on & ~async_pend & isync_pend;
    assign start_per  = (state == tspf_pkg::ST_IDLE) & trace_on & ~async_pend & ~isync_pend
                      & per_pend;
    assign start_misc = (state == tspf_pkg::ST_IDLE) & trace_on & ~async_pend & ~isync_pend
                      & ~per_pend & MISC_REQ;
    assign MISC_ACK   = start_misc;

    // Builds the packet into a staging array; the byte engine shifts it out.
    always_comb begin
        logic [31:0] rest;
        logic [3:0]  ncc;
        logic [3:0]  nctx;
        logic [3:0]  p;
        rest = 32'h0000_0000;
        ncc  = 4'h0;
        nctx = 4'h0;
        p    = 4'h0;
        for (int i = 0; i < 15; i++) begin
            next_pkt[i] = 8'h00;
        end
        if (start_misc) begin
            case (MISC_KIND)
                tspf_pkg::MISC_TRIGGER: next_pkt[0] = tspf_pkg::HDR_TRIGGER;
                tspf_pkg::MISC_EXC_RET: next_pkt[0] = tspf_pkg::HDR_EXC_RET;
                tspf_pkg::MISC_VIRTUAL_MACHINE_ID:    next_pkt[0] = tspf_pkg::HDR_VIRTUAL_MACHINE_ID;
                tspf_pkg::MISC_CTXID:   next_pkt[0] = tspf_pkg::HDR_CTXID;
                default:                next_pkt[0] = tspf_pkg::HDR_IGNORE;
            endcase
            next_pkt[1] = virtual_machine_id;
            nctx        = (ctx_bytes(ctrl[tspf_pkg::CTRL_CTXW_LSB +: 2]) == 4'h0)
                        ? 4'h4 : ctx_bytes(ctrl[tspf_pkg::CTRL_CTXW_LSB +: 2]);
            for (int i = 0; i < 4; i++) begin
                next_pkt[1 + i] = (MISC_KIND == tspf_pkg::MISC_CTXID)
                                ? last_wp.ctxid[8 * i +: 8] : next_pkt[1 + i];
            end
            if (MISC_KIND == tspf_pkg::MISC_VIRTUAL_MACHINE_ID) begin
                next_len = 4'h2;
            end else if (MISC_KIND == tspf_pkg::MISC_CTXID) begin
                next_len = nctx + 4'h1;
            end else begin
                next_len = 4'h1;
            end
        end else begin
            next_pkt[0] = tspf_pkg::HDR_ISYNC;
            next_pkt[1] = {sel_info.addr[7:1], sel_info.compact_isa};
            next_pkt[2] = sel_info.addr[15:8];
            next_pkt[3] = sel_info.addr[23:16];
            next_pkt[4] = sel_info.addr[31:24];
            next_pkt[5] = {1'b0, reason, 1'b0,
                           sel_info.nonsecure_bit,
                           sel_info.compact_isa & sel_info.alternate_isa_bit,
                           sel_info.hyp & ctrl[tspf_pkg::CTRL_VIRT],
                           1'b1};
            p = tspf_pkg::ISYNC_FIXED_LEN;
            // Leading-zero compression: only the bytes needed for the value.
            if (cyc_exact && start_np) begin
                if (cyc_val < 32'h0000_0010) begin
                    ncc = 4'h1;
                end else if (cyc_val < 32'h0000_0800) begin
                    ncc = 4'h2;
                end else if (cyc_val < 32'h0004_0000) begin
                    ncc = 4'h3;
                end else if (cyc_val < 32'h0200_0000) begin
                    ncc = 4'h4;
                end else begin
                    ncc = 4'h5;
                end
                next_pkt[p] = {1'b0, (ncc > 4'h1), cyc_val[3:0], 2'b00};
                rest        = cyc_val >> 4;
                for (int i = 1; i < 5; i++) begin
                    if (4'(i) < ncc) begin
                        next_pkt[p + 4'(i)] = {(4'(i + 1) < ncc), rest[6:0]};
                    end
                    rest = rest >> 7;
                end
                p = p + ncc;
            end
            if (ctx_en) begin
                nctx = ctx_bytes(ctrl[tspf_pkg::CTRL_CTXW_LSB +: 2]);
                for (int i = 0; i < 4; i++) begin
                    if (4'(i) < nctx) begin
                        next_pkt[p + 4'(i)] = sel_info.ctxid[8 * i +: 8];
                    end
                end
            end
            next_len = p + nctx;
        end
    end

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    assign advance    = ~TRACE_VALID | TRACE_READY;
    assign async_done = (state == tspf_pkg::ST_ASYNC) & advance
                      & (idx == {1'b0, tspf_pkg::ASYNC_ZERO_COUNT});
    assign pkt_done   = (state == tspf_pkg::ST_SEND) & advance & (idx == len - 4'h1);

    // The alignment packet runs before a waiting sync or misc packet, except a misc request already held in the cycle tracing turns on or a periodic request arrives.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= tspf_pkg::ST_IDLE;
            idx   <= 4'h0;
            len   <= 4'h0;
        end else begin
            case (state)
                tspf_pkg::ST_IDLE: begin
                    idx <= 4'h0;
                    if (trace_on & async_pend) begin
                        state <= tspf_pkg::ST_ASYNC;
                    end else if (start_np | start_per | start_misc) begin
                        state <= tspf_pkg::ST_SEND;
                        len   <= next_len;
                    end
                end
                tspf_pkg::ST_ASYNC: begin
                    if (async_done) begin
                        state <= tspf_pkg::ST_IDLE;
                    end else if (advance) begin
                        idx <= idx + 4'h1;
                    end
                end
                tspf_pkg::ST_SEND: begin
                    if (pkt_done) begin
                        state <= tspf_pkg::ST_IDLE;
                    end else if (advance) begin
                        idx <= idx + 4'h1;
                    end
                end
                default: state <= tspf_pkg::ST_IDLE;
            endcase
        end
    end

    // Staging array is frozen for the whole packet.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 15; i++) begin
                pkt[i] <= 8'h00;
            end
        end else if (start_np | start_per | start_misc) begin
            for (int i = 0; i < 15; i++) begin
                pkt[i] <= next_pkt[i];
            end
        end
    end

    // Output byte register; a stalled byte holds until the sink takes it.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TRACE_DATA  <= 8'h00;
            TRACE_VALID <= 1'b0;
        end else if (advance) begin
            if (state == tspf_pkg::ST_ASYNC) begin
                TRACE_VALID <= 1'b1;
                TRACE_DATA  <= (idx == {1'b0, tspf_pkg::ASYNC_ZERO_COUNT})
                             ? tspf_pkg::ASYNC_END : tspf_pkg::HDR_ASYNC;
            end else if (state == tspf_pkg::ST_SEND) begin
                TRACE_VALID <= 1'b1;
                TRACE_DATA  <= pkt[idx];
            end else begin
                TRACE_VALID <= 1'b0;
            end
        end
    end

endmodule : tspf_framer

// file: verif/tspf_framer_monitor.sv
// Port checker for the trace sync packet framer, bound to its top module.
module tspf_framer_monitor (
    // Clock, reset and register bus
    input wire logic                 CLK, RST, PSEL, PENABLE, PREADY, PSLVERR,
    input wire logic [11:0]          PADDR,
    // Short packet requests and the byte stream
    input wire logic                 MISC_REQ, MISC_ACK, TRACE_VALID, TRACE_READY,
    input wire tspf_pkg::tspf_misc_t MISC_KIND,
    input wire logic [7:0]           TRACE_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic       seen;
    logic       hdr_next;
    logic [2:0] zc;
    wire        acc = TRACE_VALID && TRACE_READY;
    // First accepted byte and run of zero bytes; the run saturates so it never wraps to zero.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seen     <= 1'b0;
            hdr_next <= 1'b0;
            zc       <= 3'h0;
        end else if (acc) begin
            seen     <= 1'b1;
            hdr_next <= (TRACE_DATA == 8'h80) && (zc >= 3'h5);
            zc   <= (TRACE_DATA != 8'h00) ? 3'h0 : (zc == 3'h7) ? zc : zc + 3'h1;
        end
    end
    sequence s_stall;
        TRACE_VALID && !TRACE_READY;
    endsequence
    sequence s_align_end;
        acc && TRACE_DATA == 8'h80 && zc >= 3'h5;
    endsequence
    pready_hi_a: assert property (PREADY) else $error("ready low");
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray error");
    err_unmap_a: assert property (PSEL && PENABLE && PADDR > 12'h008 |-> PSLVERR)
        else $error("unmapped access not refused");
    stall_hold_a: assert property (s_stall |=> TRACE_VALID && $stable(TRACE_DATA))
        else $error("byte changed under stall");
    ack_req_a: assert property (MISC_ACK |-> MISC_REQ) else $error("ack without request");
    first_async_a: assert property (acc && !seen |-> TRACE_DATA == 8'h00)
        else $error("first byte not alignment");
    // A stalled end byte lets the header follow with no idle cycle, so the gap is
    // checked only when the end byte went at its first offer.
    align_isync_a: assert property (s_align_end ##0 $past(TRACE_READY) |=>
        !TRACE_VALID ##1 TRACE_VALID && TRACE_DATA == 8'h08)
        else $error("no header after alignment");
    hdr_next_a: assert property (acc && hdr_next |-> TRACE_DATA == 8'h08)
        else $error("header not next after alignment");
    trig_out_a: assert property (MISC_ACK && MISC_KIND == tspf_pkg::MISC_TRIGGER |->
        ##[1:60] acc && TRACE_DATA == 8'h0C) else $error("trigger byte missing");
endmodule : tspf_framer_monitor

bind tspf_framer tspf_framer_monitor u_mon (.CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
    .PADDR, .MISC_REQ, .MISC_ACK, .TRACE_VALID, .TRACE_READY, .MISC_KIND, .TRACE_DATA);

// file: verif/tspf_sink.sv
// Trace capture sink model: takes bytes, stalls on demand and hunts for alignment.
module tspf_sink (
    input  wire logic       CLK, RST, SLOW, TRACE_VALID,
    input  wire logic [7:0] TRACE_DATA,
    output logic            TRACE_READY, SYNCED
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    logic [5:0] zbits;
    logic [1:0] ph;
    // Ready drops every third cycle while slow; forty zero bits plus the seven in 0x80 make 47.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ph          <= 2'h0;
            zbits       <= 6'h0;
            SYNCED      <= 1'b0;
            TRACE_READY <= 1'b0;
        end else begin
            ph          <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            TRACE_READY <= !(SLOW && ph == 2'h2);
            if (TRACE_VALID && TRACE_READY) begin
                q.push_back(TRACE_DATA);
                zbits <= (TRACE_DATA != 8'h00) ? 6'h0 : (zbits > 6'h27) ? zbits : zbits + 6'h8;
                if (TRACE_DATA == 8'h80 && zbits > 6'h27) SYNCED <= 1'b1;
            end
        end
    end
endmodule : tspf_sink

// file: verif/test_tspf_framer.sv
// Self-checking bench for the trace sync packet framer.
module test_tspf_framer;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, WP_VALID = 0, SLOW = 0;
    logic PERIODIC_REQ = 0, OVF_RECOVERED = 0, MISC_REQ = 0;
    logic PREADY, PSLVERR, MISC_ACK, TRACE_VALID, TRACE_READY, SYNCED;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [7:0]  TRACE_DATA, exp_q[$];
    tspf_pkg::tspf_wp_t   WP_INFO = '0;
    tspf_pkg::tspf_misc_t MISC_KIND = tspf_pkg::MISC_TRIGGER;
    int errors = 0, checks = 0;
    tspf_framer u_dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .WP_VALID, .WP_INFO, .PERIODIC_REQ, .OVF_RECOVERED, .MISC_REQ,
        .MISC_KIND, .MISC_ACK, .TRACE_DATA, .TRACE_VALID, .TRACE_READY);
    tspf_sink u_sink (.CLK, .RST, .SLOW, .TRACE_VALID, .TRACE_DATA, .TRACE_READY, .SYNCED);
    initial forever #10 CLK = ~CLK;
    // One APB transfer; read data is taken at the edge that sees ready.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Alignment then a sync packet for the fixed waypoint with four id bytes, low first.
    task automatic exp_sync(input logic [7:0] info);
        exp_q = {exp_q, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h08, 8'h35, 8'h12,
                 8'h00, 8'h00, info, 8'h44, 8'h33, 8'h22, 8'h11};
    endtask : exp_sync
    task automatic pulse(input int which);
        @(posedge CLK);
        {WP_VALID, PERIODIC_REQ} <= (which == 0) ? 2'b10 : 2'b01;
        @(posedge CLK);
        {WP_VALID, PERIODIC_REQ} <= 2'b00;
    endtask : pulse
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 400 && u_sink.q.size() < n; i++) @(posedge CLK);
    endtask : wait_bytes
    // The request is held until the framer takes it, then one idle cycle follows.
    task automatic misc(input tspf_pkg::tspf_misc_t k, input logic [7:0] b);
        @(posedge CLK);
        {MISC_REQ, MISC_KIND} <= {1'b1, k};
        do @(posedge CLK); while (MISC_ACK !== 1'b1);
        MISC_REQ <= 1'b0;
        exp_q.push_back(b);
    endtask : misc
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        apb(1'b0, tspf_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl reset", tspf_pkg::CTRL_RESET, rd);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped read", 32'h0, rd);
        WP_INFO <= {32'h0000_1234, 4'b1111, 1'b0, 32'h1122_3344};
        pulse(0);
        apb(1'b1, tspf_pkg::CTRL_OFFSET, 32'h0002_E001); // Enable, id 4 bytes, virtualization.
        pulse(0);
        exp_sync(8'h2F);
        wait_bytes(16);
        chk("sink aligned", 32'h1, {31'h0, SYNCED});
        SLOW <= 1'b1;
        pulse(1);
        exp_sync(8'h0F);
        wait_bytes(32);
        misc(tspf_pkg::MISC_TRIGGER, 8'h0C);
        misc(tspf_pkg::MISC_EXC_RET, 8'h76);
        misc(tspf_pkg::MISC_IGNORE, 8'h66);
        apb(1'b1, tspf_pkg::VIRTUAL_MACHINE_ID_OFFSET, 32'h0000_005A);
        apb(1'b0, tspf_pkg::VIRTUAL_MACHINE_ID_OFFSET, 32'h0);
        chk("virtual_machine_id readback", 32'h0000_005A, rd);
        misc(tspf_pkg::MISC_VIRTUAL_MACHINE_ID, 8'h3C);
        exp_q.push_back(8'h5A);
        wait_bytes(37);
        chk("byte count", exp_q.size(), u_sink.q.size());
        foreach (exp_q[i]) chk("stream byte", exp_q[i], u_sink.q[i]);
        wrap_up();
    end
endmodule : test_tspf_framer
